// *** rtl/expansion_map_params.svh ***
`ifndef EXPANSION_MAP_PARAMS_SVH
`define EXPANSION_MAP_PARAMS_SVH
// ----------------------------------------
// Address map
// ----------------------------------------
`define ALIAS_BIT         28
`define SLOT_SIZE         32'h0000_1000
`define CODE_LO           32'h0000_0000
`define CODE_HI           32'h007F_FFFF
`define SRAM_LOW_LO       32'h2800_0000
`define SRAM_LOW_HI       32'h281F_FFFF
`define SRAM_HIGH_LO      32'h2820_0000
`define SRAM_HIGH_HI      32'h283F_FFFF
`define PSRAM_LO          32'h8000_0000
`define PSRAM_HI          32'h80FF_FFFF
`define GPIO_LO           32'h4010_0000
`define GPIO_HI           32'h4010_3FFF
`define DMA_LO            32'h4011_0000
`define DMA_HI            32'h4011_1FFF
`define SERIAL_LO         32'h4020_0000
`define SERIAL_HI         32'h4020_DFFF
`define SCC_LO            32'h4030_0000
`define SCC_HI            32'h4030_2FFF
`define VGA_TEXT_LO       32'h4100_0000
`define VGA_TEXT_HI       32'h4100_FFFF
`define VGA_IMG_LO        32'h4110_0000
`define VGA_IMG_HI        32'h4113_FFFF
`define ETH_LO            32'h4200_0000
`define ETH_HI            32'h420F_FFFF
`define NS_PRIV_ADDR      32'h4800_7000
`define CNT_READ_ADDR     32'h4810_4000
`define MPC_LOW_CFG_ADDR  32'h5800_8000
`define MPC_HIGH_CFG_ADDR 32'h5800_9000
`define CODE_MPC_CFG_ADDR 32'h5810_0000
`define CNT_CTRL_ADDR     32'h5810_5000
// ----------------------------------------
// Slots and attribution identifiers
// ----------------------------------------
`define GPIO_FIRST        5'h00
`define DMA_FIRST         5'h04
`define SERIAL_FIRST      5'h06
`define SLOT_OTHER        5'h1F
`define ATTR_CODE_NS      4'h0
`define ATTR_CODE_S       4'h1
`define ATTR_SRAM_NS      4'h2
`define ATTR_SRAM_S       4'h3
`define ATTR_PERIPH_NS    4'h4
`define ATTR_PERIPH_S     4'h5
`define ATTR_PSRAM_NS     4'h8
// ----------------------------------------
// Protection controller configuration
// ----------------------------------------
`define MPC_ADDR_WIDTH    22
`define MPC_DATA_WIDTH    32
`define MPC_MASTER_WIDTH  5
`define MPC_USER_WIDTH    0
`define PROT_BLOCK_LOG2   11
`define LOCK_RESP_SELECT  1'b0
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define REG_IRQ_STATUS    6'h00
`define REG_IRQ_CLEAR     6'h04
`define REG_IRQ_ENABLE    6'h08
`define REG_MPC_LOCK      6'h0C
`define REG_MSC_NONSEC    6'h10
`define REG_MSC_MASK      6'h14
`define REG_PPC_NS_EN     6'h18
`define REG_PPC_S_EN      6'h1C
`define REG_LUT_INDEX     6'h20
`define REG_LUT_DATA      6'h24
`define REG_ERR_ADDR      6'h28
`define RST_IRQ_ENABLE    4'h0
`define RST_MSC_MASK      32'h0000_0000
`define RST_PPC_EN        20'h0_0000
`endif

// *** rtl/expansion_map_pkg.sv ***
`include "expansion_map_params.svh"
package expansion_map_pkg;
	typedef enum logic [3:0] {
		TGT_NONE      = 4'b0000,
		TGT_CODE_SRAM = 4'b0001,
		TGT_SRAM_LOW  = 4'b0010,
		TGT_SRAM_HIGH = 4'b0011,
		TGT_PSRAM     = 4'b0100,
		TGT_PERIPH    = 4'b0101,
		TGT_MPC_LOW   = 4'b0110,
		TGT_MPC_HIGH  = 4'b0111,
		TGT_MPC_CODE  = 4'b1000,
		TGT_CNT_CTRL  = 4'b1001
	} target_type;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_FORWARD = 3'b001,
		ST_LOCK    = 3'b010,
		ST_ERR1    = 3'b011,
		ST_ERR2    = 3'b100
	} state_type;
	typedef struct packed {
		state_type         state;
		target_type        tgt_sel;
		logic [23:0]       tgt_addr;
		logic              tgt_write;
		logic              tgt_valid;
		logic              tgt_nonsec;
		logic [4:0]        slot;
		logic [4:0]        master;
		logic [3:0]        attr;
		logic [31:0]       req_addr;
		logic              hreadyout;
		logic              hresp;
		logic [3:0]        irq_vec;
		logic [3:0]        irq_enable;
		logic              irq;
		logic [1:0]        mpc_lock;
		logic [31:0]       msc_nonsec;
		logic [31:0]       msc_mask;
		logic [19:0]       ppc_ns_en;
		logic [19:0]       ppc_s_en;
		logic [5:0]        lut_index;
		logic [31:0][31:0] lut_low;
		logic [31:0][31:0] lut_high;
		logic [31:0]       err_addr;
		logic              waitrequest;
		logic [31:0]       readdata;
	} core_state_type;
endpackage

// *** rtl/region_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "expansion_map_params.svh"
module region_decoder (
	input  wire logic [31:0]             addr,
	output var  expansion_map_pkg::target_type target,
	output var  logic                    secure_region,
	output var  logic [4:0]              slot,
	output var  logic [23:0]             offset,
	output var  logic [3:0]              attr
);
	import expansion_map_pkg::*;

	logic [31:0] base;
	logic        sec;

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	function automatic logic in_slot(input logic [31:0] a, input logic [31:0] lo);
		return in_range(a, lo, lo + `SLOT_SIZE - 32'h0000_0001);
	endfunction

	function automatic logic [4:0] slot_of(input logic [31:0] a, input logic [31:0] lo, input logic [4:0] first);
		return first + (a[16:12] - lo[16:12]);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// The secure alias of each region except PSRAM, the NS_PRIV_ADDR slot and the secure-only config and counter control slots sits one alias bit higher, so the
	// rest of the non-secure map is decoded once on the address with that bit cleared.
	always_comb begin
		sec = addr[`ALIAS_BIT];
		base = addr & ~(32'h0000_0001 << `ALIAS_BIT);
		target = TGT_NONE;
		secure_region = sec;
		slot = `SLOT_OTHER;
		offset = addr[23:0];
		attr = sec ? `ATTR_PERIPH_S : `ATTR_PERIPH_NS;
		if (in_slot(addr, `MPC_LOW_CFG_ADDR)) begin // [RULE_06] [RULE_16]
			target = TGT_MPC_LOW;
		end else if (in_slot(addr, `MPC_HIGH_CFG_ADDR)) begin // [RULE_07] [RULE_16]
			target = TGT_MPC_HIGH;
		end else if (in_slot(addr, `CODE_MPC_CFG_ADDR)) begin // [RULE_16]
			target = TGT_MPC_CODE;
		end else if (in_slot(addr, `CNT_CTRL_ADDR)) begin // [RULE_16]
			target = TGT_CNT_CTRL;
		end else if (in_range(base, `CODE_LO, `CODE_HI)) begin // [RULE_01]
			target = TGT_CODE_SRAM;
			offset = {2'b00, addr[21:0]}; // [RULE_02]
			attr = sec ? `ATTR_CODE_S : `ATTR_CODE_NS;
		end else if (in_range(base, `SRAM_LOW_LO, `SRAM_LOW_HI)) begin // [RULE_04]
			target = TGT_SRAM_LOW;
			offset = {3'b000, addr[20:0]};
			attr = sec ? `ATTR_SRAM_S : `ATTR_SRAM_NS; // [RULE_17]
		end else if (in_range(base, `SRAM_HIGH_LO, `SRAM_HIGH_HI)) begin // [RULE_04]
			target = TGT_SRAM_HIGH;
			offset = {3'b000, addr[20:0]};
			attr = sec ? `ATTR_SRAM_S : `ATTR_SRAM_NS; // [RULE_17]
		end else if (!sec && in_range(addr, `PSRAM_LO, `PSRAM_HI)) begin // [RULE_11]
			target = TGT_PSRAM;
			attr = `ATTR_PSRAM_NS;
		end else if (in_range(base, `GPIO_LO, `GPIO_HI)) begin // [RULE_12] [RULE_15]
			target = TGT_PERIPH;
			slot = slot_of(base, `GPIO_LO, `GPIO_FIRST);
		end else if (in_range(base, `DMA_LO, `DMA_HI)) begin // [RULE_15]
			target = TGT_PERIPH;
			slot = slot_of(base, `DMA_LO, `DMA_FIRST);
		end else if (in_range(base, `SERIAL_LO, `SERIAL_HI)) begin // [RULE_15]
			target = TGT_PERIPH;
			slot = slot_of(base, `SERIAL_LO, `SERIAL_FIRST);
		end else if (in_range(base, `SCC_LO, `SCC_HI) || in_range(base, `VGA_TEXT_LO, `VGA_TEXT_HI)
				|| in_range(base, `VGA_IMG_LO, `VGA_IMG_HI) || in_range(base, `ETH_LO, `ETH_HI)
				|| in_slot(base, `CNT_READ_ADDR) || (!sec && in_slot(base, `NS_PRIV_ADDR))) begin // [RULE_12]
			target = TGT_PERIPH;
		end
	end
endmodule
`default_nettype wire

// *** rtl/expansion_memory_map_decoder.sv ***
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "expansion_map_params.svh"
// How it works
// RULE_01: Code SRAM sits at zero non-secure and at 0x1000_0000 secure.
// RULE_02: Upper 4MB of each 8MB code window aliases the lower 4MB.
// RULE_03: Unused expansion, code or PSRAM space ends in a bus error.
// RULE_04: Expansion SRAMs at 0x2800_0000 and 0x2820_0000, secure aliases 0x1000_0000 higher.
// RULE_05: Each expansion SRAM path has its own protection lookup per block.
// RULE_06: Low SRAM protection config at 0x5800_8000, interrupt on vector bit 1.
// RULE_07: High SRAM protection config at 0x5800_9000, interrupt on vector bit 2.
// RULE_08: Protection controllers use 22-bit address, 32-bit data, 5-bit master.
// RULE_09: Protection block is two to the power eleven bytes.
// RULE_10: Accesses during a programming lock get wait states until released.
// RULE_11: 16MB PSRAM only non-secure at 0x8000_0000; rest of window errors.
// RULE_12: Expansion peripherals in 0x4010_0000 up, secure copy at 0x5010_0000 up.
// RULE_13: Duplicated peripherals gated by per-slot secure and non-secure enables.
// RULE_14: Expansion masters get their security from a per-master controller.
// RULE_15: Peripherals take 4K slots: GPIO, DMA and serial groups, secure copy higher.
// RULE_16: Protection configs and counter control decode only in secure space.
// RULE_17: Expansion SRAM attributes are identifier 2 non-secure and 3 secure.
// RULE_18: A bus error takes two cycles: ready low, then ready high.
module expansion_memory_map_decoder (
	input  wire logic                          CORE_CLK,
	input  wire logic                          RST,
	input  wire logic                          HSEL,
	input  wire logic [31:0]                   HADDR,
	input  wire logic [1:0]                    HTRANS,
	input  wire logic                          HWRITE,
	input  wire logic                          HREADY,
	input  wire logic                          HNONSEC,
	input  wire logic [4:0]                    HMASTER,
	output logic                               HREADYOUT,
	output logic                               HRESP,
	output expansion_map_pkg::target_type      TGT_SEL,
	output logic [23:0]                        TGT_ADDR,
	output logic                               TGT_WRITE,
	output logic                               TGT_VALID,
	output logic                               TGT_NONSEC,
	output logic [4:0]                         TGT_SLOT,
	output logic [4:0]                         TGT_MASTER,
	output logic [3:0]                         TGT_ATTR,
	input  wire logic                          TGT_DONE,
	input  wire logic [5:0]                    AVS_ADDRESS,
	input  wire logic                          AVS_READ,
	input  wire logic                          AVS_WRITE,
	input  wire logic [31:0]                   AVS_WRITEDATA,
	input  wire logic [3:0]                    AVS_BYTEENABLE,
	output logic [31:0]                        AVS_READDATA,
	output logic                               AVS_WAITREQUEST,
	output logic [3:0]                         SECURE_PROTECTION_IRQ_VECTOR,
	output logic                               IRQ
);
	import expansion_map_pkg::*;

	core_state_type q;
	core_state_type n;
	target_type     dec_target;
	logic           dec_secure;
	logic [4:0]     dec_slot;
	logic [23:0]    dec_offset;
	logic [3:0]     dec_attr;
	logic           req_ns;
	logic [3:0]     ev;
	logic [3:0]     clr;
	logic [31:0]    wmerge;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic locked(input target_type t, input logic [1:0] lock);
		return ((t == TGT_SRAM_LOW) && lock[0]) || ((t == TGT_SRAM_HIGH) && lock[1]);
	endfunction

	// Each lookup bit covers one protection block; 1 marks it non-secure.
	function automatic logic mpc_denied(input target_type t, input logic [23:0] off, input logic ns,
			input logic [31:0][31:0] lo, input logic [31:0][31:0] hi);
		logic [4:0] w;
		logic [4:0] b;
		logic       blk_ns;
		w = off[`PROT_BLOCK_LOG2+9:`PROT_BLOCK_LOG2+5]; // [RULE_09]
		b = off[`PROT_BLOCK_LOG2+4:`PROT_BLOCK_LOG2];
		blk_ns = (t == TGT_SRAM_HIGH) ? hi[w][b] : lo[w][b];
		return ((t == TGT_SRAM_LOW) || (t == TGT_SRAM_HIGH)) && (blk_ns != ns); // [RULE_05]
	endfunction

	function automatic logic ppc_allowed(input logic [4:0] s, input logic sec,
			input logic [19:0] ns_en, input logic [19:0] s_en);
		if (s == `SLOT_OTHER) begin
			return 1'b1;
		end
		return sec ? s_en[s] : ns_en[s];
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	region_decoder i_region_decoder (
		.addr          (HADDR),
		.target        (dec_target),
		.secure_region (dec_secure),
		.slot          (dec_slot),
		.offset        (dec_offset),
		.attr          (dec_attr)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = q;
		ev = 4'h0;
		clr = 4'h0;
		wmerge = 32'h0000_0000;
		n.tgt_valid = 1'b0;
		// Masters under the security controller ignore their own attribute.
		req_ns = q.msc_mask[HMASTER] ? q.msc_nonsec[HMASTER] : HNONSEC; // [RULE_14]

		case (q.state)
			ST_IDLE, ST_ERR2: begin
				n.state = ST_IDLE;
				n.hreadyout = 1'b1;
				n.hresp = 1'b0;
				if (HSEL && HTRANS[1] && HREADY) begin
					n.tgt_sel = dec_target;
					n.tgt_addr = dec_offset;
					n.tgt_write = HWRITE;
					n.tgt_nonsec = req_ns;
					n.slot = dec_slot;
					n.master = HMASTER; // [RULE_08]
					n.attr = dec_attr;
					n.req_addr = HADDR;
					n.hreadyout = 1'b0;
					if ((dec_target == TGT_NONE) || (dec_secure && req_ns)) begin // [RULE_03] [RULE_16]
						n.state = ST_ERR1;
						n.hresp = 1'b1; // [RULE_18]
						n.err_addr = HADDR;
						ev[0] = 1'b1;
					end else if ((dec_target == TGT_PERIPH)
							&& !ppc_allowed(dec_slot, dec_secure, q.ppc_ns_en, q.ppc_s_en)) begin // [RULE_13]
						n.state = ST_ERR1;
						n.hresp = 1'b1;
						n.err_addr = HADDR;
						ev[3] = 1'b1;
					end else if (locked(dec_target, q.mpc_lock)) begin
						if (`LOCK_RESP_SELECT) begin
							n.state = ST_ERR1;
							n.hresp = 1'b1;
							n.err_addr = HADDR;
						end else begin
							n.state = ST_LOCK; // [RULE_10]
						end
					end else if (mpc_denied(dec_target, dec_offset, req_ns, q.lut_low, q.lut_high)) begin
						n.state = ST_ERR1;
						n.hresp = 1'b1;
						n.err_addr = HADDR;
						ev[1] = (dec_target == TGT_SRAM_LOW); // [RULE_06]
						ev[2] = (dec_target == TGT_SRAM_HIGH); // [RULE_07]
					end else begin
						n.state = ST_FORWARD;
						n.tgt_valid = 1'b1;
					end
				end
			end
			ST_FORWARD: begin
				if (TGT_DONE) begin
					n.state = ST_IDLE;
					n.hreadyout = 1'b1;
				end
			end
			ST_LOCK: begin
				// Wait states are held while software reprograms the lookup.
				if (!locked(q.tgt_sel, q.mpc_lock)) begin // [RULE_10]
					if (mpc_denied(q.tgt_sel, q.tgt_addr, q.tgt_nonsec, q.lut_low, q.lut_high)) begin // [RULE_05]
						n.state = ST_ERR1;
						n.hresp = 1'b1;
						n.err_addr = q.req_addr;
						ev[1] = (q.tgt_sel == TGT_SRAM_LOW);
						ev[2] = (q.tgt_sel == TGT_SRAM_HIGH);
					end else begin
						n.state = ST_FORWARD;
						n.tgt_valid = 1'b1;
					end
				end
			end
			ST_ERR1: begin
				n.state = ST_ERR2; // [RULE_18]
				n.hreadyout = 1'b1;
				n.hresp = 1'b1;
			end
			default: begin
				n.state = ST_IDLE;
				n.hreadyout = 1'b1;
				n.hresp = 1'b0;
			end
		endcase

		// ----------------------------------------
		// Register slave
		// ----------------------------------------
		// The answer comes one cycle after the request is seen; a write
		// commits only on the edge that sees waitrequest low.
		n.waitrequest = 1'b1;
		if ((AVS_READ || AVS_WRITE) && q.waitrequest) begin
			n.waitrequest = 1'b0;
			n.readdata = 32'h0000_0000;
			if (AVS_ADDRESS == `REG_IRQ_STATUS) begin
				n.readdata = {28'h000_0000, q.irq_vec};
			end else if (AVS_ADDRESS == `REG_IRQ_ENABLE) begin
				n.readdata = {28'h000_0000, q.irq_enable};
			end else if (AVS_ADDRESS == `REG_MPC_LOCK) begin
				n.readdata = {30'h0000_0000, q.mpc_lock};
			end else if (AVS_ADDRESS == `REG_MSC_NONSEC) begin
				n.readdata = q.msc_nonsec;
			end else if (AVS_ADDRESS == `REG_MSC_MASK) begin
				n.readdata = q.msc_mask;
			end else if (AVS_ADDRESS == `REG_PPC_NS_EN) begin
				n.readdata = {12'h000, q.ppc_ns_en};
			end else if (AVS_ADDRESS == `REG_PPC_S_EN) begin
				n.readdata = {12'h000, q.ppc_s_en};
			end else if (AVS_ADDRESS == `REG_LUT_INDEX) begin
				n.readdata = {26'h000_0000, q.lut_index};
			end else if (AVS_ADDRESS == `REG_LUT_DATA) begin
				n.readdata = q.lut_index[5] ? q.lut_high[q.lut_index[4:0]] : q.lut_low[q.lut_index[4:0]];
			end else if (AVS_ADDRESS == `REG_ERR_ADDR) begin
				n.readdata = q.err_addr;
			end
		end

		if (AVS_WRITE && !q.waitrequest) begin
			if (AVS_ADDRESS == `REG_IRQ_CLEAR) begin
				wmerge = merge(32'h0000_0000, AVS_WRITEDATA, AVS_BYTEENABLE);
				clr = wmerge[3:0];
			end else if (AVS_ADDRESS == `REG_IRQ_ENABLE) begin
				wmerge = merge({28'h000_0000, q.irq_enable}, AVS_WRITEDATA, AVS_BYTEENABLE);
				n.irq_enable = wmerge[3:0];
			end else if (AVS_ADDRESS == `REG_MPC_LOCK) begin
				wmerge = merge({30'h0000_0000, q.mpc_lock}, AVS_WRITEDATA, AVS_BYTEENABLE);
				n.mpc_lock = wmerge[1:0];
			end else if (AVS_ADDRESS == `REG_MSC_NONSEC) begin
				n.msc_nonsec = merge(q.msc_nonsec, AVS_WRITEDATA, AVS_BYTEENABLE); // [RULE_14]
			end else if (AVS_ADDRESS == `REG_MSC_MASK) begin
				n.msc_mask = merge(q.msc_mask, AVS_WRITEDATA, AVS_BYTEENABLE);
			end else if (AVS_ADDRESS == `REG_PPC_NS_EN) begin
				wmerge = merge({12'h000, q.ppc_ns_en}, AVS_WRITEDATA, AVS_BYTEENABLE);
				n.ppc_ns_en = wmerge[19:0]; // [RULE_13]
			end else if (AVS_ADDRESS == `REG_PPC_S_EN) begin
				wmerge = merge({12'h000, q.ppc_s_en}, AVS_WRITEDATA, AVS_BYTEENABLE);
				n.ppc_s_en = wmerge[19:0]; // [RULE_13]
			end else if (AVS_ADDRESS == `REG_LUT_INDEX) begin
				wmerge = merge({26'h000_0000, q.lut_index}, AVS_WRITEDATA, AVS_BYTEENABLE);
				n.lut_index = wmerge[5:0];
			end else if (AVS_ADDRESS == `REG_LUT_DATA) begin
				if (q.lut_index[5]) begin
					n.lut_high[q.lut_index[4:0]] = merge(q.lut_high[q.lut_index[4:0]], AVS_WRITEDATA,
						AVS_BYTEENABLE); // [RULE_05]
				end else begin
					n.lut_low[q.lut_index[4:0]] = merge(q.lut_low[q.lut_index[4:0]], AVS_WRITEDATA,
						AVS_BYTEENABLE); // [RULE_05]
				end
			end
		end

		// ----------------------------------------
		// Interrupts
		// ----------------------------------------
		// A new event in the clearing cycle survives the clear.
		n.irq_vec = (q.irq_vec & ~clr) | ev; // [RULE_06] [RULE_07]
		n.irq = |(n.irq_vec & n.irq_enable);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			q <= '0;
			q.state <= ST_IDLE;
			q.tgt_sel <= TGT_NONE;
			q.hreadyout <= 1'b1;
			q.waitrequest <= 1'b1;
			q.irq_enable <= `RST_IRQ_ENABLE;
			q.msc_mask <= `RST_MSC_MASK;
			q.ppc_ns_en <= `RST_PPC_EN;
			q.ppc_s_en <= `RST_PPC_EN;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign HREADYOUT = q.hreadyout;
	assign HRESP = q.hresp;
	assign TGT_SEL = q.tgt_sel;
	assign TGT_ADDR = q.tgt_addr;
	assign TGT_WRITE = q.tgt_write;
	assign TGT_VALID = q.tgt_valid;
	assign TGT_NONSEC = q.tgt_nonsec;
	assign TGT_SLOT = q.slot;
	assign TGT_MASTER = q.master;
	assign TGT_ATTR = q.attr;
	assign AVS_READDATA = q.readdata;
	assign AVS_WAITREQUEST = q.waitrequest;
	assign SECURE_PROTECTION_IRQ_VECTOR = q.irq_vec;
	assign IRQ = q.irq;
endmodule
`default_nettype wire

// *** tb/expansion_map_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module expansion_map_assertions (
	input	wire logic				CORE_CLK,
	input	wire logic				RST,
	input	wire logic				HSEL,
	input	wire logic [31:0]			HADDR,
	input	wire logic [1:0]			HTRANS,
	input	wire logic				HREADY,
	input	wire logic				HNONSEC,
	input	wire logic				HREADYOUT,
	input	wire logic				HRESP,
	input	wire logic [3:0]			TGT_SEL,
	input	wire logic [23:0]			TGT_ADDR,
	input	wire logic				TGT_VALID,
	input	wire logic [4:0]			TGT_SLOT,
	input	wire logic [3:0]			TGT_ATTR,
	input	wire logic				AVS_READ,
	input	wire logic				AVS_WRITE,
	input	wire logic				AVS_WAITREQUEST,
	input	wire logic [3:0]			SECURE_PROTECTION_IRQ_VECTOR,
	input	wire logic				IRQ
);
	import expansion_map_pkg::*;
	logic	acc;
	assign acc = HSEL && HTRANS[1] && HREADY && HREADYOUT;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	sequence err_two;
		!HREADYOUT && HRESP ##1 HREADYOUT && HRESP;
	endsequence
	AST_ERR_SHAPE: assert property ($rose(HRESP) |-> err_two)
		else $error("error response shape wrong");
	AST_UNUSED: assert property (acc && (HADDR[31:28] == 4'h9 || HADDR[31:23] == 9'h001
		|| HADDR[31:22] == 10'h0A1) |=> err_two) else $error("unused space not refused");
	AST_NO_TARGET: assert property (HRESP |-> !TGT_VALID)
		else $error("target started during error");
	AST_CODE: assert property (acc && HNONSEC && HADDR[31:23] == 9'h000 |=> TGT_VALID
		&& TGT_SEL == TGT_CODE_SRAM && TGT_ADDR == {2'b00, $past(HADDR[21:0])}) else $error("code alias wrong");
	AST_SEC_ONLY: assert property (acc && HNONSEC && (HADDR[31:28] == 4'h5 || HADDR[31:28] == 4'h1)
		|=> err_two) else $error("secure space reached non-secure");
	AST_SRAM_NS: assert property (acc && HADDR[31:22] == 10'h0A0 |=> HRESP || TGT_ATTR == 4'h2)
		else $error("sram attribute wrong");
	AST_SRAM_S: assert property (acc && HADDR[31:22] == 10'h0E0 |=> HRESP || TGT_ATTR == 4'h3)
		else $error("secure sram attribute wrong");
	AST_PSRAM: assert property (acc && HNONSEC && HADDR[31:24] == 8'h80 |=> TGT_VALID
		&& TGT_SEL == TGT_PSRAM && TGT_ATTR == 4'h8) else $error("psram decode wrong");
	AST_DMA_SLOT: assert property (acc && HADDR[31:29] == 3'b010 && HADDR[27:12] == 16'h0111
		|=> HRESP || TGT_SLOT == 5'h05) else $error("dma slot wrong");
	AST_VALID_PULSE: assert property (TGT_VALID |-> !HREADYOUT ##1 !TGT_VALID)
		else $error("target start not a pulse");
	AST_AVS_ANSWER: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
		else $error("register answer late");
	AST_IRQ: assert property (IRQ |-> SECURE_PROTECTION_IRQ_VECTOR != 4'h0)
		else $error("interrupt without status");
endmodule
bind expansion_memory_map_decoder expansion_map_assertions i_expansion_map_assertions (.*);
`default_nettype wire

// *** tb/target_responder.sv ***
`timescale 1ns/100ps
`default_nettype none
module target_responder (
	input	wire logic		clk,
	input	wire logic		rst,
	input	wire logic		valid,
	input	wire logic [3:0]	lag,
	output	logic			done
);
	logic [3:0]	cnt = 4'h0;
	logic		busy = 1'b0;
	// A random lag per transfer covers both fast and slow memories.
	always @(posedge clk) begin
		done <= 1'b0;
		if (rst) begin
			busy <= 1'b0;
		end else if (valid) begin
			busy <= 1'b1;
			cnt <= lag;
		end else if (busy && cnt == 4'h0) begin
			busy <= 1'b0;
			done <= 1'b1;
		end else if (busy) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** tb/tb_expansion_memory_map_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_expansion_memory_map_decoder;
	import expansion_map_pkg::*;
	logic		CORE_CLK = 0, RST = 1, HSEL = 0, HWRITE = 0, HREADY = 1, HNONSEC = 0;
	logic [31:0]	HADDR = 0, AVS_WRITEDATA = 0, AVS_READDATA, r;
	logic [1:0]	HTRANS = 0;
	logic [4:0]	HMASTER = 0, TGT_SLOT, TGT_MASTER;
	logic [5:0]	AVS_ADDRESS = 0;
	logic [3:0]	AVS_BYTEENABLE = 4'hF, lag = 0, TGT_ATTR, SECURE_PROTECTION_IRQ_VECTOR;
	logic		AVS_READ = 0, AVS_WRITE = 0, HREADYOUT, HRESP, TGT_WRITE, TGT_VALID, TGT_NONSEC;
	logic		TGT_DONE, AVS_WAITREQUEST, IRQ;
	logic [23:0]	TGT_ADDR;
	target_type	TGT_SEL;
	int		fail_count = 0, samples_checked = 0, seed = 32'h175e;
	expansion_memory_map_decoder i_expansion_memory_map_decoder (.*);
	target_responder i_target_responder (.clk(CORE_CLK), .rst(RST), .valid(TGT_VALID), .lag(lag), .done(TGT_DONE));
	always #12.5 CORE_CLK = ~CORE_CLK;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic [31:0] off(input logic [31:0] a, input target_type t);
		if (t == TGT_CODE_SRAM)
			return a & 32'h003F_FFFF;
		if (t == TGT_SRAM_LOW || t == TGT_SRAM_HIGH)
			return a & 32'h001F_FFFF;
		return a & 32'h00FF_FFFF;
	endfunction
	// A request is held until the rising edge that sees the answer; only the watchdog ends a wait.
	task automatic avs(input logic wr, input logic [5:0] ad, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge CORE_CLK);
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		AVS_ADDRESS <= ad;
		AVS_WRITEDATA <= wd;
		do begin
			@(posedge CORE_CLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask
	task automatic go(input logic [31:0] a, input logic ns, input target_type t);
		logic [31:0] q;
		q = $random(seed);
		@(posedge CORE_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= a;
		HNONSEC <= ns;
		HWRITE <= q[0];
		HMASTER <= q[5:1];
		lag <= q[9:6];
		@(posedge CORE_CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		do begin
			@(posedge CORE_CLK);
		end while (HREADYOUT !== 1'b1);
		chk("resp", HRESP, t == TGT_NONE);
		if (t != TGT_NONE) begin
			chk("sel", TGT_SEL, t);
			chk("addr", TGT_ADDR, off(a, t));
			chk("ctl", {TGT_WRITE, TGT_MASTER, TGT_NONSEC}, {q[0], q[5:1], ns});
		end
		@(posedge CORE_CLK);
	endtask
	initial begin
		repeat (8) @(posedge CORE_CLK);
		RST <= 1'b0;
		avs(0, 6'h00, 0, r);
		chk("status_rst", r, 0);
		avs(0, 6'h3C, 0, r);
		chk("unmapped", r, 0);
		go(32'h0000_0010, 1, TGT_CODE_SRAM);
		go(32'h1040_0020, 0, TGT_CODE_SRAM);
		go(32'h1000_0020, 1, TGT_NONE);
		go(32'h0080_0000, 1, TGT_NONE);
		go(32'h2840_0000, 1, TGT_NONE);
		go(32'h80FF_FFFC, 1, TGT_PSRAM);
		go(32'h8100_0000, 1, TGT_NONE);
		go(32'h9000_0000, 0, TGT_NONE);
		go(32'h5800_8000, 0, TGT_MPC_LOW);
		go(32'h5800_9000, 0, TGT_MPC_HIGH);
		go(32'h5810_0000, 0, TGT_MPC_CODE);
		go(32'h5810_5000, 0, TGT_CNT_CTRL);
		go(32'h4800_8000, 1, TGT_NONE);
		go(32'h5800_8000, 1, TGT_NONE);
		$display("test map done");
		go(32'h4010_0000, 1, TGT_NONE);
		avs(1, 6'h18, 32'h0008_0001, r);
		avs(1, 6'h1C, 32'h0000_0020, r);
		go(32'h4010_0000, 1, TGT_PERIPH);
		go(32'h4020_D000, 1, TGT_PERIPH);
		chk("slot", TGT_SLOT, 19);
		go(32'h5011_1000, 0, TGT_PERIPH);
		go(32'h4011_1000, 1, TGT_NONE);
		$display("test gating done");
		avs(1, 6'h04, 32'h0000_000F, r);
		avs(1, 6'h20, 0, r);
		avs(1, 6'h24, 32'h0000_0001, r);
		go(32'h2800_0010, 1, TGT_SRAM_LOW);
		chk("attr", TGT_ATTR, 2);
		go(32'h2800_0800, 1, TGT_NONE);
		go(32'h3800_0800, 0, TGT_SRAM_LOW);
		chk("attr", TGT_ATTR, 3);
		go(32'h3820_0000, 0, TGT_SRAM_HIGH);
		go(32'h2820_0000, 1, TGT_NONE);
		avs(0, 6'h00, 0, r);
		chk("status", r & 32'h6, 32'h6);
		avs(1, 6'h08, 32'h0000_0002, r);
		repeat (2) @(negedge CORE_CLK);
		chk("irq", IRQ, 1);
		avs(1, 6'h04, 32'h0000_000F, r);
		repeat (2) @(negedge CORE_CLK);
		chk("irq_clr", {IRQ, SECURE_PROTECTION_IRQ_VECTOR}, 0);
		$display("test protection done");
		avs(1, 6'h0C, 32'h0000_0001, r);
		fork
			go(32'h2800_0010, 1, TGT_SRAM_LOW);
			begin
				repeat (6) @(negedge CORE_CLK);
				chk("lock_wait", HREADYOUT, 0);
				avs(1, 6'h0C, 0, r);
			end
		join
		avs(1, 6'h10, 32'hFFFF_FFFF, r);
		avs(1, 6'h14, 32'hFFFF_FFFF, r);
		go(32'h1000_0020, 0, TGT_NONE);
		avs(1, 6'h14, 0, r);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed) & 32'h007F_FFFC;
			go(r, 1, TGT_CODE_SRAM);
		end
		$display("test lock and random done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
